// file: src/dram_command_bus_decoder.v
// Command/address bus decoder: pairs bus words into commands and polices their order
//
// Summary of operation
// - Illegal event sets fault until reset
// - Commands take two cycles, idle one
// - Don't-care bus bits are ignored; self-refresh entry with bit5 high is still flagged illegal
// - Bank index selects target bank
// - All-banks flag applies to every bank
// - Auto-close flag closes row after access
// - Burst bit picks 32 or 16 beats
// - Masked write is 16 beats, bit5 low
// - Column bits one and zero are zero
// - Column half decode with column bits
// - Row-close and refresh decode
// - Inputs sampled at true clock rise
// - Low clock gate disables input capture
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
`include "cmd_decoder_defs.vh"
module dram_command_bus_decoder (
    // Clock and reset
    input  wire        clock,
    input  wire        rst_b,
    // Command/address pins
    input  wire        clock_gate,
    input  wire        select,
    input  wire [5:0]  command_address_bus,
    // Avalon-MM slave
    input  wire [1:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output wire [31:0] readdata,
    output wire        waitrequest,
    // Decoded commands
    output reg         cmd_valid_q,
    output reg  [3:0]  cmd_code_q,
    output reg  [2:0]  cmd_bank_q,
    output reg         cmd_all_banks_q,
    output reg         cmd_auto_close_q,
    output reg         cmd_burst32_q,
    output reg  [9:0]  cmd_column_q,
    output reg  [14:0] cmd_row_q,
    output reg  [7:0]  cmd_payload_q,
    output reg  [5:0]  cmd_index_q,
    // Status
    output reg         illegal_q,
    output reg         fault_q,
    output reg         retain_q,
    output reg         power_down_q
);

localparam S_FIRST  = 1'b0;
localparam S_SECOND = 1'b1;

////////////////////////////////////////////////////////////////////////////////
// First-cycle opcode decode

function [3:0] classify;
    input [5:0] ca;
    begin
        casez (ca[4:0])
            5'b00000: classify = `OP_MPC;
            5'b10000: classify = `OP_PRE;
            5'b01000: classify = `OP_REF;
            5'b11000: classify = `OP_SRE;
            5'b00100: classify = `OP_WR1;
            5'b10100: classify = `OP_SRX;
            5'b01100: classify = `OP_MWR1;
            5'b00010: classify = `OP_RD1;
            5'b10010: classify = `OP_CAS2;
            5'b00110: classify = `OP_MRW1;
            5'b10110: classify = `OP_MRW2;
            5'b01110: classify = `OP_MRR1;
            5'b???01: classify = `OP_ACT1;
            5'b???11: classify = `OP_ACT2;
            default:  classify = `OP_RSVD;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// State

reg         state_q;
reg  [2:0]  want_q;
reg  [3:0]  pend_op_q;
reg  [2:0]  pend_bank_q;
reg         pend_ap_q;
reg         pend_b32_q;
reg         pend_c9_q;
reg  [4:0]  pend_row_q;
reg  [5:0]  pend_index_q;
reg         pend_op7_q;
reg  [15:0] cmd_cnt_q;
reg  [15:0] bad_cnt_q;

wire [5:0]  first_ca;
wire [3:0]  first_op;
wire        first_bad;
wire [1:0]  ctrl;
wire [3:0]  op_now;
wire [6:0]  mpc_code;
reg         bad_now;

assign op_now   = classify(command_address_bus);
assign mpc_code = {first_ca[5], command_address_bus};

// Legality of a first half against what the previous command demands
always @* begin
    bad_now = 1'b0;
    if (want_q == `WANT_CAS) begin
        bad_now = (op_now != `OP_CAS2);
    end else if (want_q == `WANT_ACT2) begin
        bad_now = (op_now != `OP_ACT2);
    end else if (want_q == `WANT_MRW2) begin
        bad_now = (op_now != `OP_MRW2);
    end else if (want_q != `WANT_NONE) begin
        bad_now = 1'b1;
    end else begin
        bad_now = (op_now == `OP_CAS2) || (op_now == `OP_ACT2) || (op_now == `OP_MRW2);
    end
    if (op_now == `OP_RSVD) begin
        bad_now = 1'b1;
    end
    if ((op_now == `OP_MWR1 || op_now == `OP_SRE) && command_address_bus[5]) begin
        bad_now = 1'b1;
    end
end

// First half is held over into the second cycle
first_half_latch u_first (
    .clock  (clock),
    .rst_b  (rst_b),
    .load   (clock_gate && select && state_q == S_FIRST),
    .ca_in  (command_address_bus),
    .op_in  (op_now),
    .bad_in (bad_now),
    .ca_q   (first_ca),
    .op_q   (first_op),
    .bad_q  (first_bad)
);

avalon_regs u_regs (
    .clock       (clock),
    .rst_b       (rst_b),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .status_in   ({3'h0, want_q == `WANT_NONE, power_down_q, retain_q, state_q, fault_q}),
    .cmd_cnt     (cmd_cnt_q),
    .bad_cnt     (bad_cnt_q),
    .ctrl_q      (ctrl)
);

////////////////////////////////////////////////////////////////////////////////
// Sequencer

always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        state_q          <= S_FIRST;
        want_q           <= `WANT_NONE;
        pend_op_q        <= `OP_MPC;
        pend_bank_q      <= 3'h0;
        pend_ap_q        <= 1'b0;
        pend_b32_q       <= 1'b0;
        pend_c9_q        <= 1'b0;
        pend_row_q       <= 5'h00;
        pend_index_q     <= 6'h00;
        pend_op7_q       <= 1'b0;
        cmd_valid_q      <= 1'b0;
        cmd_code_q       <= `OP_MPC;
        cmd_bank_q       <= 3'h0;
        cmd_all_banks_q  <= 1'b0;
        cmd_auto_close_q <= 1'b0;
        cmd_burst32_q    <= 1'b0;
        cmd_column_q     <= 10'h000;
        cmd_row_q        <= 15'h0000;
        cmd_payload_q    <= 8'h00;
        cmd_index_q      <= 6'h00;
        illegal_q        <= 1'b0;
        fault_q          <= 1'b0;
        retain_q         <= 1'b0;
        power_down_q     <= 1'b0;
        cmd_cnt_q        <= 16'h0000;
        bad_cnt_q        <= 16'h0000;
    end else begin
        cmd_valid_q  <= 1'b0;
        illegal_q    <= 1'b0;
        power_down_q <= !clock_gate;
        if (cmd_valid_q) begin
            cmd_cnt_q <= cmd_cnt_q + 16'h0001;
        end
        if (illegal_q) begin
            fault_q   <= 1'b1;
            bad_cnt_q <= bad_cnt_q + 16'h0001;
        end
        if (!clock_gate) begin
            // Input buffers off: a pair or a demanded follow-up cut short is illegal
            state_q <= S_FIRST;
            if (state_q == S_SECOND || want_q == `WANT_CAS || want_q == `WANT_ACT2 || want_q == `WANT_MRW2) begin
                illegal_q <= 1'b1;
            end
            want_q <= `WANT_NONE;
        end else if (state_q == S_FIRST) begin
            if (select) begin
                state_q <= S_SECOND;
                if (bad_now) begin
                    illegal_q <= 1'b1;
                    want_q    <= `WANT_NONE;
                end
            end else begin
                // Idle word: bus bits are not looked at
                if (want_q == `WANT_CAS || want_q == `WANT_ACT2 || want_q == `WANT_MRW2) begin
                    illegal_q <= 1'b1;
                    want_q    <= `WANT_NONE;
                end else if (want_q == `WANT_IDLE2) begin
                    want_q <= `WANT_IDLE1;
                end else begin
                    want_q <= `WANT_NONE;
                end
            end
        end else begin
            state_q <= S_FIRST;
            if (select || first_bad) begin
                illegal_q <= select;
                want_q    <= `WANT_NONE;
            end else begin
                want_q        <= `WANT_NONE;
                cmd_code_q    <= first_op;
                cmd_bank_q    <= command_address_bus[2:0];
                cmd_all_banks_q <= 1'b0;
                cmd_auto_close_q <= 1'b0;
                cmd_burst32_q <= 1'b0;
                case (first_op)
                    `OP_MPC: begin
                        cmd_payload_q <= {1'b0, mpc_code};
                        if (mpc_code == `MPC_FIFO_WR || mpc_code == `MPC_FIFO_RD || mpc_code == `MPC_RD_CAL) begin
                            pend_op_q <= `OP_MPC;
                            want_q    <= `WANT_CAS;
                        end else begin
                            cmd_valid_q <= 1'b1;
                            if (mpc_code == `MPC_OSC_START || mpc_code == `MPC_OSC_STOP ||
                                mpc_code == `MPC_ZQ_START || mpc_code == `MPC_ZQ_LATCH) begin
                                want_q <= `WANT_IDLE2;
                            end
                        end
                    end
                    `OP_PRE, `OP_REF: begin
                        cmd_valid_q     <= 1'b1;
                        cmd_all_banks_q <= first_ca[5];
                        cmd_bank_q      <= first_ca[5] ? 3'h0 : command_address_bus[2:0];
                    end
                    `OP_SRE: begin
                        cmd_valid_q <= 1'b1;
                        retain_q    <= 1'b1;
                    end
                    `OP_SRX: begin
                        cmd_valid_q <= 1'b1;
                        retain_q    <= 1'b0;
                    end
                    `OP_WR1, `OP_MWR1, `OP_RD1: begin
                        pend_op_q   <= first_op;
                        pend_bank_q <= command_address_bus[2:0];
                        pend_c9_q   <= command_address_bus[4];
                        pend_ap_q   <= command_address_bus[5];
                        if (first_op == `OP_MWR1) begin
                            pend_b32_q <= 1'b0;
                        end else if (ctrl[`CTRL_OTF_BIT]) begin
                            pend_b32_q <= first_ca[5];
                        end else begin
                            pend_b32_q <= ctrl[`CTRL_B32_BIT];
                        end
                        want_q <= `WANT_CAS;
                    end
                    `OP_MRR1: begin
                        pend_op_q    <= `OP_MRR1;
                        pend_index_q <= command_address_bus;
                        want_q       <= `WANT_CAS;
                    end
                    `OP_CAS2: begin
                        if ((pend_op_q == `OP_WR1 || pend_op_q == `OP_MWR1) && command_address_bus[1:0] != 2'h0) begin
                            illegal_q <= 1'b1;
                        end else begin
                            cmd_valid_q      <= 1'b1;
                            cmd_code_q       <= pend_op_q;
                            cmd_bank_q       <= pend_bank_q;
                            cmd_auto_close_q <= pend_ap_q;
                            cmd_burst32_q    <= pend_b32_q;
                            cmd_index_q      <= pend_index_q;
                            cmd_column_q     <= {pend_c9_q, first_ca[5], command_address_bus, 2'b00};
                        end
                    end
                    `OP_MRW1: begin
                        pend_index_q <= command_address_bus;
                        pend_op7_q   <= first_ca[5];
                        want_q       <= `WANT_MRW2;
                    end
                    `OP_MRW2: begin
                        cmd_valid_q   <= 1'b1;
                        cmd_index_q   <= pend_index_q;
                        cmd_payload_q <= {pend_op7_q, first_ca[5], command_address_bus};
                    end
                    `OP_ACT1: begin
                        pend_bank_q <= command_address_bus[2:0];
                        pend_row_q  <= {first_ca[4:2], command_address_bus[5:4]};
                        want_q      <= `WANT_ACT2;
                    end
                    `OP_ACT2: begin
                        cmd_valid_q <= 1'b1;
                        cmd_bank_q  <= pend_bank_q;
                        cmd_row_q   <= {pend_row_q, first_ca[5:2], command_address_bus};
                    end
                    default: begin
                        illegal_q <= 1'b1;
                    end
                endcase
            end
        end
    end
end

endmodule

// file: src/cmd_decoder_defs.vh
// Constants for the command/address bus decoder and its register slave
`ifndef CMD_DECODER_DEFS_VH
`define CMD_DECODER_DEFS_VH

// Decoded opcodes
`define OP_MPC        4'h0
`define OP_PRE        4'h1
`define OP_REF        4'h2
`define OP_SRE        4'h3
`define OP_WR1        4'h4
`define OP_SRX        4'h5
`define OP_MWR1       4'h6
`define OP_RD1        4'h7
`define OP_CAS2       4'h8
`define OP_MRW1       4'h9
`define OP_MRW2       4'ha
`define OP_MRR1       4'hb
`define OP_ACT1       4'hc
`define OP_ACT2       4'hd
`define OP_RSVD       4'hf

// What the next cycle must carry
`define WANT_NONE     3'h0
`define WANT_CAS      3'h1
`define WANT_ACT2     3'h2
`define WANT_MRW2     3'h3
`define WANT_IDLE2    3'h4
`define WANT_IDLE1    3'h5

// Multi-purpose operation payload codes
`define MPC_FIFO_WR   7'h47
`define MPC_FIFO_RD   7'h41
`define MPC_RD_CAL    7'h43
`define MPC_OSC_START 7'h4b
`define MPC_OSC_STOP  7'h4d
`define MPC_ZQ_START  7'h4f
`define MPC_ZQ_LATCH  7'h51

// Register word offsets
`define REG_CTRL      2'h0
`define REG_STATUS    2'h1
`define REG_CMD_CNT   2'h2
`define REG_BAD_CNT   2'h3

// Control fields and reset value
`define CTRL_OTF_BIT  0
`define CTRL_B32_BIT  1
`define CTRL_RESET    2'h0

`endif

// file: src/first_half_latch.v
// Holds the first-cycle bus word, opcode and its legality during the second cycle
`timescale 1ns/100ps
module first_half_latch (
    // Clock and reset
    input  wire       clock,
    input  wire       rst_b,
    // Capture
    input  wire       load,
    input  wire [5:0] ca_in,
    input  wire [3:0] op_in,
    input  wire       bad_in,
    // Held word
    output reg  [5:0] ca_q,
    output reg  [3:0] op_q,
    output reg        bad_q
);

always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        ca_q  <= 6'h00;
        op_q  <= 4'h0;
        bad_q <= 1'b0;
    end else if (load) begin
        ca_q  <= ca_in;
        op_q  <= op_in;
        bad_q <= bad_in;
    end
end

endmodule

// file: src/avalon_regs.v
// Avalon-MM slave with control, status and counter registers
`timescale 1ns/100ps
`include "cmd_decoder_defs.vh"
module avalon_regs (
    // Clock and reset
    input  wire        clock,
    input  wire        rst_b,
    // Avalon-MM slave
    input  wire [1:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    // Block state
    input  wire [7:0]  status_in,
    input  wire [15:0] cmd_cnt,
    input  wire [15:0] bad_cnt,
    output reg  [1:0]  ctrl_q
);

always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        waitrequest <= 1'b1;
        readdata    <= 32'h00000000;
        ctrl_q      <= `CTRL_RESET;
    end else if ((read || write) && waitrequest) begin
        waitrequest <= 1'b0;
        if (address == `REG_CTRL) begin
            readdata <= {30'h00000000, ctrl_q};
        end else if (address == `REG_STATUS) begin
            readdata <= {24'h000000, status_in};
        end else if (address == `REG_CMD_CNT) begin
            readdata <= {16'h0000, cmd_cnt};
        end else begin
            readdata <= {16'h0000, bad_cnt};
        end
    end else begin
        waitrequest <= 1'b1;
        if (write && !waitrequest && address == `REG_CTRL) begin
            ctrl_q <= writedata[1:0];
        end
    end
end

endmodule

// file: tb/decoder_props.sv
// Concurrent checks on the command bus decoder ports
`timescale 1ns/100ps
`include "cmd_decoder_defs.vh"
module decoder_props (
    // Clock and reset
    input wire       clock,
    input wire       rst_b,
    // Bus pins
    input wire       clock_gate,
    input wire       select,
    input wire [5:0] command_address_bus,
    // Decoded outputs
    input wire       cmd_valid_q,
    input wire [3:0] cmd_code_q,
    input wire [2:0] cmd_bank_q,
    input wire       cmd_all_banks_q,
    input wire       cmd_burst32_q,
    input wire [9:0] cmd_column_q,
    input wire       illegal_q,
    input wire       fault_q,
    input wire       power_down_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_one_event: assert property (!(cmd_valid_q && illegal_q))
        else $error("valid and illegal together");
    a_fault_set: assert property (illegal_q |=> fault_q [*3])
        else $error("fault not held");
    a_pair_gap: assert property (cmd_valid_q |=> !cmd_valid_q)
        else $error("commands closer than two cycles");
    a_pair_shape: assert property (cmd_valid_q |-> !$past(select) && $past(select, 2))
        else $error("command without select pair");
    a_gate_high: assert property (cmd_valid_q |-> $past(clock_gate) && $past(clock_gate, 2))
        else $error("command taken with gate low");
    a_col_zero: assert property (cmd_valid_q |-> cmd_column_q[1:0] == 2'h0)
        else $error("low column bits set");
    a_masked_b16: assert property (cmd_valid_q && cmd_code_q == `OP_MWR1 |-> !cmd_burst32_q)
        else $error("masked write not 16 beats");
    a_close_decode: assert property (cmd_valid_q && cmd_code_q == `OP_PRE |->
        $past(command_address_bus[4:0], 2) == 5'h10 && cmd_all_banks_q == $past(command_address_bus[5], 2))
        else $error("row close decode wrong");
    a_bank_field: assert property (cmd_valid_q && !cmd_all_banks_q && cmd_code_q inside {`OP_PRE, `OP_REF}
        |-> cmd_bank_q == $past(command_address_bus[2:0]))
        else $error("bank index wrong");
    a_power_down: assert property (power_down_q == !$past(clock_gate))
        else $error("power down flag wrong");
endmodule
bind dram_command_bus_decoder decoder_props u_props (.clock, .rst_b, .clock_gate, .select, .command_address_bus,
    .cmd_valid_q, .cmd_code_q, .cmd_bank_q, .cmd_all_banks_q, .cmd_burst32_q, .cmd_column_q, .illegal_q,
    .fault_q, .power_down_q);

// file: tb/ctrl_model.sv
// Memory controller model driving the command/address pins
`timescale 1ns/100ps
module ctrl_model (
    // Clock
    input wire       clock,
    // Command pins
    output reg       clock_gate,
    output reg       select,
    output reg [5:0] command_address_bus
);
    initial begin
        clock_gate = 1'b1;
        select = 1'b0;
        command_address_bus = 6'h15;
    end
    // Two-cycle command, both words at defined levels, changed just after the edge
    task send(input [5:0] w1, input [5:0] w2);
        begin
            @(posedge clock);
            select <= 1'b1;
            command_address_bus <= w1;
            @(posedge clock);
            select <= 1'b0;
            command_address_bus <= w2;
        end
    endtask
    // Deselect cycles; floating bits shown as a toggling pattern
    task idle(input integer n);
        repeat (n) begin
            @(posedge clock);
            select <= 1'b0;
            command_address_bus <= ~command_address_bus;
        end
    endtask
    task gate(input v);
        begin
            @(posedge clock);
            clock_gate <= v;
        end
    endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the command bus decoder
`timescale 1ns/100ps
`include "cmd_decoder_defs.vh"
module testbench;
    reg         clock;
    reg         rst_b;
    reg  [1:0]  address;
    reg         read;
    reg         write;
    reg  [31:0] writedata;
    wire [31:0] readdata;
    wire        waitrequest;
    wire        clock_gate;
    wire        select;
    wire [5:0]  command_address_bus;
    wire        cmd_valid_q;
    wire [3:0]  cmd_code_q;
    wire [2:0]  cmd_bank_q;
    wire        cmd_all_banks_q;
    wire        cmd_auto_close_q;
    wire        cmd_burst32_q;
    wire [9:0]  cmd_column_q;
    wire [14:0] cmd_row_q;
    wire [7:0]  cmd_payload_q;
    wire [5:0]  cmd_index_q;
    wire        illegal_q;
    wire        fault_q;
    wire        retain_q;
    wire        power_down_q;
    wire [19:0] got = {cmd_code_q, cmd_bank_q, cmd_all_banks_q, cmd_auto_close_q, cmd_burst32_q, cmd_column_q};
    integer     bad_count = 0;
    integer     samples_checked = 0;
    integer     cycles = 0;
    integer     k;
    reg  [31:0] seed = 32'h1ce6ca3a;
    reg  [31:0] q;
    reg  [40:0] exp_q[$];
    reg  [40:0] e;
    reg  [9:0]  col;
    reg  [6:0]  pl;
    reg  [5:0]  w1;
    reg  [5:0]  w2;
    reg  [3:0]  code;
    reg         b32;

    dram_command_bus_decoder DUT (.clock(clock), .rst_b(rst_b), .clock_gate(clock_gate), .select(select),
        .command_address_bus(command_address_bus), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .cmd_valid_q(cmd_valid_q),
        .cmd_code_q(cmd_code_q), .cmd_bank_q(cmd_bank_q), .cmd_all_banks_q(cmd_all_banks_q),
        .cmd_auto_close_q(cmd_auto_close_q), .cmd_burst32_q(cmd_burst32_q), .cmd_column_q(cmd_column_q),
        .cmd_row_q(cmd_row_q), .cmd_payload_q(cmd_payload_q), .cmd_index_q(cmd_index_q),
        .illegal_q(illegal_q), .fault_q(fault_q),
        .retain_q(retain_q), .power_down_q(power_down_q));
    ctrl_model u_ctrl (.clock(clock), .clock_gate(clock_gate), .select(select),
        .command_address_bus(command_address_bus));

    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task fail(input string s);
        begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: %0s", $time, s);
        end
    endtask
    task chk(input ok);
        begin
            samples_checked = samples_checked + 1;
            if (ok !== 1'b1) fail("value differs");
        end
    endtask
    task expect_cmd(input ill, input [19:0] msk, input [19:0] val);
        exp_q.push_back({ill, msk, val});
    endtask
    task end_sim;
        begin
            $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // Avalon-MM master: hold the request until waitrequest is seen low
    task bus(input wr, input [1:0] a, input [31:0] d);
        begin
            @(posedge clock);
            write <= wr;
            read <= !wr;
            address <= a;
            writedata <= d;
            @(posedge clock);
            while (waitrequest !== 1'b0) @(posedge clock);
            q = readdata;
            write <= 1'b0;
            read <= 1'b0;
        end
    endtask
    task do_reset;
        begin
            @(posedge clock);
            rst_b <= 1'b0;
            repeat (4) @(posedge clock);
            rst_b <= 1'b1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Result watcher and hang limit
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fail("timeout");
            end_sim;
        end
        if (cmd_valid_q === 1'b1 || illegal_q === 1'b1) begin
            if (exp_q.size() == 0) fail("unexpected output");
            else begin
                e = exp_q.pop_front();
                samples_checked = samples_checked + 1;
                if (e[40] !== illegal_q || (!e[40] && ((got ^ e[19:0]) & e[39:20]) !== 20'h0))
                    fail("decoded command differs");
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        address = 2'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        bus(1'b0, `REG_CTRL, 32'h0);
        chk(q[1:0] === `CTRL_RESET);
        // Accesses completed by a column half, random fields and burst settings
        for (k = 0; k < 10; k = k + 1) begin
            seed = lfsr(seed);
            bus(1'b1, `REG_CTRL, seed);
            bus(1'b0, `REG_CTRL, 32'h0);
            chk(q[1:0] === seed[1:0]);
            col = {seed[11:4], 2'b00};
            pl = (k < 5) ? `MPC_FIFO_WR : `MPC_RD_CAL;
            w2 = {seed[13], col[9], seed[14], seed[4:2]};
            case (k % 5)
                0: begin code = `OP_WR1; w1 = {seed[12], 5'b00100}; end
                1: begin code = `OP_MWR1; w1 = 6'h0c; end
                2: begin code = `OP_RD1; w1 = {seed[12], 5'b00010}; end
                3: begin code = `OP_MRR1; w1 = {seed[12], 5'b01110}; w2 = seed[5:0]; end
                default: begin code = `OP_MPC; w1 = {pl[6], 5'b00000}; w2 = pl[5:0]; end
            endcase
            if (k % 5 < 2) col[3:2] = 2'b00;
            b32 = (k % 5 == 1) ? 1'b0 : seed[0] ? seed[12] : seed[1];
            u_ctrl.send(w1, w2);
            u_ctrl.send({col[8], 5'b10010}, col[7:2]);
            expect_cmd(1'b0, (k % 5 < 3) ? 20'hfefff : 20'hf01ff, {code, seed[4:2], 1'b0, seed[13], b32, col});
        end
        // Row close and refresh, per bank and all banks, back to back
        for (k = 0; k < 4; k = k + 1) begin
            seed = lfsr(seed);
            u_ctrl.send({k[0], k[1] ? 5'b01000 : 5'b10000}, seed[5:0]);
            expect_cmd(1'b0, k[0] ? 20'hf1000 : 20'hff000, {k[1] ? `OP_REF : `OP_PRE, seed[2:0], k[0], 12'h0});
        end
        pl = `MPC_OSC_START;
        u_ctrl.send({pl[6], 5'b00000}, pl[5:0]);
        expect_cmd(1'b0, 20'hf0000, {`OP_MPC, 16'h0});
        u_ctrl.idle(2);
        chk(cmd_payload_q === {1'b0, pl});
        u_ctrl.send(6'h10, 6'h03);
        expect_cmd(1'b0, 20'hff000, {`OP_PRE, 3'h3, 13'h0});
        u_ctrl.send(6'h18, seed[5:0]);
        expect_cmd(1'b0, 20'hf0000, {`OP_SRE, 16'h0});
        u_ctrl.idle(2);
        chk(retain_q === 1'b1);
        u_ctrl.send({seed[0], 5'b10100}, seed[5:0]);
        expect_cmd(1'b0, 20'hf0000, {`OP_SRX, 16'h0});
        u_ctrl.idle(2);
        chk(retain_q === 1'b0);
        // Row open and setting write pairs, then their held fields
        seed = lfsr(seed);
        u_ctrl.send({seed[5:2], 2'b01}, seed[11:6]);
        u_ctrl.send({seed[15:12], 2'b11}, seed[21:16]);
        expect_cmd(1'b0, 20'hfe000, {`OP_ACT2, seed[8:6], 13'h0});
        u_ctrl.send({seed[22], 5'b00110}, seed[27:22]);
        u_ctrl.send({seed[23], 5'b10110}, seed[29:24]);
        expect_cmd(1'b0, 20'hf0000, {`OP_MRW2, 16'h0});
        u_ctrl.idle(2);
        chk(cmd_row_q === {seed[4:2], seed[11:10], seed[15:12], seed[21:16]});
        chk(cmd_payload_q === {seed[22], seed[23], seed[29:24]});
        chk(cmd_index_q === seed[27:22]);
        u_ctrl.gate(1'b0);
        u_ctrl.send(6'h10, 6'h01);
        u_ctrl.idle(1);
        chk(power_down_q === 1'b1);
        u_ctrl.gate(1'b1);
        u_ctrl.idle(2);
        bus(1'b0, `REG_CMD_CNT, 32'h0);
        chk(q[15:0] === 16'h0014);
        bus(1'b0, `REG_BAD_CNT, 32'h0);
        chk(q[15:0] === 16'h0000);
        bus(1'b0, `REG_STATUS, 32'h0);
        chk(q[4:0] === 5'h10);
        // Refused sequences, each followed by a reset
        for (k = 0; k < 8; k = k + 1) begin
            seed = lfsr(seed);
            case (k)
                0: u_ctrl.send(6'h2c, seed[5:0]);
                1: u_ctrl.send(6'h1c, seed[5:0]);
                2: begin u_ctrl.send(6'h01, seed[5:0]); u_ctrl.send(6'h10, 6'h00); end
                3: begin u_ctrl.send(6'h06, seed[5:0]); u_ctrl.idle(1); end
                4: begin u_ctrl.send({pl[6], 5'h0}, pl[5:0]); expect_cmd(1'b0, 20'hf0000, 20'h0); u_ctrl.send(6'h10, 6'h00); end
                5: u_ctrl.send(6'h12, seed[5:0]);
                6: begin u_ctrl.send(6'h04, 6'h00); u_ctrl.send(6'h12, 6'h01); end
                default: begin u_ctrl.send(6'h01, 6'h00); u_ctrl.send(6'h01, 6'h00); end
            endcase
            expect_cmd(1'b1, 20'h0, 20'h0);
            u_ctrl.idle(3);
            chk(fault_q === 1'b1);
            bus(1'b0, `REG_BAD_CNT, 32'h0);
            chk(q[15:0] === 16'h0001);
            do_reset;
            chk(fault_q === 1'b0);
        end
        if (exp_q.size() != 0) fail("missing output");
        end_sim;
    end
endmodule
